// ### include/cantm_map.svh
// Constants of the CAN transceiver mode and pin controller.
// Assumes a 200 MHz CLOCK; counts are derived from nanosecond figures.
`ifndef CANTM_MAP_SVH
`define CANTM_MAP_SVH

// ==========================================================
// Timing
// ==========================================================
`define CANTM_CLK_NS        5
`define CANTM_DOM_TO_NS     1000000
`define CANTM_START_NS      100000
`define CANTM_INH_OFF_NS    200000
`define CANTM_WAKE_FILT_NS  50000
`define CANTM_CYC(ns) (((ns) + `CANTM_CLK_NS - 1) / `CANTM_CLK_NS)
`define CANTM_DOM_TO_CYC    `CANTM_CYC(`CANTM_DOM_TO_NS)
`define CANTM_START_CYC     `CANTM_CYC(`CANTM_START_NS)
`define CANTM_INH_OFF_CYC   `CANTM_CYC(`CANTM_INH_OFF_NS)
`define CANTM_WAKE_FILT_CYC `CANTM_CYC(`CANTM_WAKE_FILT_NS)

// ==========================================================
// Mode field codes
// ==========================================================
`define CANTM_DEV_NORMAL    3'h7
`define CANTM_DEV_STANDBY   3'h4
`define CANTM_DEV_SLEEP     3'h1
`define CANTM_TRX_STANDBY   2'h0
`define CANTM_TRX_SILENT    2'h3

// ==========================================================
// Positions in the pin synchroniser vector
// ==========================================================
`define CANTM_SY_BAT   0
`define CANTM_SY_IO    1
`define CANTM_SY_OVT   2
`define CANTM_SY_TX    3
`define CANTM_SY_RXS   4
`define CANTM_SY_BUS   5
`define CANTM_SY_WAKE  6
`define CANTM_SY_CS    7
`define CANTM_SY_SCK   8
`define CANTM_SY_SDI   9
`define CANTM_SY_N     10

`endif

// ### include/cantm_pkg.sv
// Types of the CAN transceiver mode and pin controller.
// Assumes cantm_map.svh supplies the numeric constants.
`default_nettype none

package cantm_pkg;

	// ======================================================
	// Operating modes, Gray along off-standby-normal
	// ======================================================
	typedef enum logic [2:0]
	{
		CANTM_OFF   = 3'h0,
		CANTM_STBY  = 3'h1,
		CANTM_NORM  = 3'h3,
		CANTM_SLEEP = 3'h2,
		CANTM_MRST  = 3'h6,
		CANTM_OVT   = 3'h7
	} cantm_mode_e;

	// Cycle counter
	typedef logic [19:0] cantm_cnt_t;

endpackage

`default_nettype wire

// ### rtl/cantm_dom_timer.sv
// Dominant time-out timer on the transmit input.
// Assumes tx_low is synchronous to CLOCK.
`timescale 1ns/1ps
`default_nettype none
`include "cantm_map.svh"

module cantm_dom_timer
	import cantm_pkg::*;
#(
	parameter cantm_cnt_t LIMIT = cantm_cnt_t'(`CANTM_DOM_TO_CYC)
)
(
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic tx_low,
	output var  logic timed_out
);

	// ======================================================
	// Counter
	// ======================================================
	cantm_cnt_t count;      // Cycles of dominant request
	cantm_cnt_t next_count; // Next count
	logic       expired;    // Limit passed

	// Saturates past the limit, clears on a high input
	assign expired    = (count > LIMIT);
	assign next_count = !tx_low ? '0 :
		(expired ? count : count + cantm_cnt_t'(1));
	assign timed_out  = expired;

	// Count register
	always_ff @(posedge clock)
	begin
		if (!nrst)
			count <= '0;
		else
			count <= next_count;
	end

endmodule

`default_nettype wire

// ### rtl/cantm_wake_filter.sv
// Local wake input filter and edge detector.
// Assumes level is already synchronised to clock.
`timescale 1ns/1ps
`default_nettype none
`include "cantm_map.svh"

module cantm_wake_filter
	import cantm_pkg::*;
#(
	parameter cantm_cnt_t FILT = cantm_cnt_t'(`CANTM_WAKE_FILT_CYC)
)
(
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic level,
	input  wire logic rise_en,
	input  wire logic fall_en,
	output var  logic wake_event
);

	// ======================================================
	// Filter state
	// ======================================================
	logic       held;       // Accepted level
	cantm_cnt_t count;      // Cycles level differs
	logic       settled;    // New level lasted long enough
	logic       next_event; // Enabled edge accepted

	// Short pulses restart the count and never reach held
	assign settled    = (level != held) && (count >= FILT - 1);
	assign next_event = settled && (level ? rise_en : fall_en);

	// Filter registers
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			held       <= 1'b0;
			count      <= '0;
			wake_event <= 1'b0;
		end
		else
		begin
			held       <= settled ? level : held;
			count      <= (level == held || settled) ? '0 :
				count + cantm_cnt_t'(1);
			wake_event <= next_event;
		end
	end

endmodule

`default_nettype wire

// ### rtl/cantm_mode_ctrl.sv
// Mode controller and pin logic of a high-speed CAN transceiver.
// Assumes pins arrive asynchronously; register-side inputs share CLOCK.
//
// Behaviour
// - Normal mode, transmit high: drivers off, recessive
// - Transmit low drives the bus dominant
// - Standby drivers off; sleep and off passive
// - Floating transmit input reads as high
// - Dominant time-out releases bus until high
// - Low at Normal entry blocks until high
// - Receive output follows bus in Normal, Silent
// - Standby receive high, low after wake-up
// - Receive clamped recessive blocks transmission
// - Inhibit on in Normal, Standby; off Sleep
// - Wake-up or power-up switches inhibit on
// - Watchdog reset turns inhibit off briefly
// - Filtered rising or falling local wake edge
// - Serial output released while select high
// - Serial clock idles low
// - Select active low gates sampling, output
// - Serial port enable depends on mode
// - Transceiver sub-state from transceiver mode field
// - Low battery forces Power Off
// - Power-up initialises, then Standby after delay
// - Code 111 moves to Normal; wake stays
// - Code 0x4 gives Standby with io supply
// - Refused sleep request lands in Standby
`timescale 1ns/1ps
`default_nettype none
`include "cantm_map.svh"

module cantm_mode_ctrl
	import cantm_pkg::*;
#(
	parameter cantm_cnt_t DOM_TO_CYC  = cantm_cnt_t'(`CANTM_DOM_TO_CYC),
	parameter cantm_cnt_t START_CYC   = cantm_cnt_t'(`CANTM_START_CYC),
	parameter cantm_cnt_t INH_OFF_CYC = cantm_cnt_t'(`CANTM_INH_OFF_CYC),
	parameter cantm_cnt_t FILT_CYC    = cantm_cnt_t'(`CANTM_WAKE_FILT_CYC)
)
(
	input  wire logic       CLOCK,
	input  wire logic       NRST,
	input  wire logic       BATTERY_ON,
	input  wire logic       IO_SUPPLY_OK,
	input  wire logic       OVERTEMP,
	input  wire logic       TX_DATA_IN,
	input  wire logic       TX_DATA_DRIVEN,
	output var  logic       RX_DATA_OUT,
	input  wire logic       RX_DATA_SENSE,
	input  wire logic       BUS_RECESSIVE,
	output var  logic       BUS_DRIVE_DOM,
	output var  logic       BUS_BIAS_ON,
	output var  logic       BUS_HIGH_OHMIC,
	output var  logic       REGULATOR_INHIBIT_OUT,
	input  wire logic       WAKE_IN,
	input  wire logic       WAKE_RISE_EN,
	input  wire logic       WAKE_FALL_EN,
	input  wire logic       BUS_WAKE_EN,
	input  wire logic       BUS_WAKE_EVENT,
	input  wire logic       WAKE_CLEAR,
	output var  logic       WAKE_PENDING,
	input  wire logic       WDOG_ENABLE,
	input  wire logic       WDOG_RESET,
	input  wire logic       MODE_WRITE,
	input  wire logic [2:0] DEVICE_MODE_FIELD,
	input  wire logic [1:0] TRANSCEIVER_MODE_FIELD,
	output var  logic [2:0] DEVICE_MODE,
	input  wire logic       SPI_SELECT_N,
	input  wire logic       SERIAL_CLOCK,
	input  wire logic       SERIAL_IN,
	output var  logic       SERIAL_OUT,
	output var  logic       SERIAL_OUT_OE_N,
	input  wire logic       SERIAL_OUT_DATA,
	output var  logic       SPI_ENABLE,
	output var  logic       SERIAL_IN_BIT,
	output var  logic       SERIAL_IN_STROBE,
	output var  logic       SERIAL_OUT_SHIFT
);

	// ======================================================
	// Decode helpers
	// ======================================================

	// Inhibit switch state for a mode
	function automatic logic inh_on(input cantm_mode_e m);
		inh_on = (m == CANTM_STBY) || (m == CANTM_NORM) ||
			(m == CANTM_OVT);
	endfunction

	// ======================================================
	// Pin synchronisers
	// ======================================================
	logic [`CANTM_SY_N-1:0] pin_raw; // Asynchronous pin levels
	logic [`CANTM_SY_N-1:0] sync1;   // First stage, read by sync2 only
	logic [`CANTM_SY_N-1:0] sync2;   // Stable pin levels
	logic                   tx_pin;  // Transmit with pull-up applied

	// Undriven transmit input is pulled toward io supply
	assign tx_pin = TX_DATA_IN | ~TX_DATA_DRIVEN;

	assign pin_raw[`CANTM_SY_BAT]  = BATTERY_ON;
	assign pin_raw[`CANTM_SY_IO]   = IO_SUPPLY_OK;
	assign pin_raw[`CANTM_SY_OVT]  = OVERTEMP;
	assign pin_raw[`CANTM_SY_TX]   = tx_pin;
	assign pin_raw[`CANTM_SY_RXS]  = RX_DATA_SENSE;
	assign pin_raw[`CANTM_SY_BUS]  = BUS_RECESSIVE;
	assign pin_raw[`CANTM_SY_WAKE] = WAKE_IN;
	assign pin_raw[`CANTM_SY_CS]   = SPI_SELECT_N;
	assign pin_raw[`CANTM_SY_SCK]  = SERIAL_CLOCK;
	assign pin_raw[`CANTM_SY_SDI]  = SERIAL_IN;

	// Two flip-flops per pin
	for (genvar i = 0; i < `CANTM_SY_N; i++)
	begin : g_sync
		always_ff @(posedge CLOCK)
		begin
			if (!NRST)
			begin
				sync1[i] <= 1'b0;
				sync2[i] <= 1'b0;
			end
			else
			begin
				sync1[i] <= pin_raw[i];
				sync2[i] <= sync1[i];
			end
		end
	end

	// Named stable levels
	wire bat_on  = sync2[`CANTM_SY_BAT];
	wire io_ok   = sync2[`CANTM_SY_IO];
	wire ovt     = sync2[`CANTM_SY_OVT];
	wire tx_low  = !sync2[`CANTM_SY_TX];
	wire rx_sens = sync2[`CANTM_SY_RXS];
	wire bus_rec = sync2[`CANTM_SY_BUS];
	wire cs_high = sync2[`CANTM_SY_CS];
	wire sck     = sync2[`CANTM_SY_SCK];
	wire serial_in     = sync2[`CANTM_SY_SDI];

	// ======================================================
	// Wake-up sources
	// ======================================================
	logic lw_event;  // Filtered local wake edge
	logic pend;      // Wake-up pending
	logic wake_ev;   // Any enabled wake event this cycle
	logic no_src;    // Every wake source disabled
	logic sleep_ok;  // Sleep request may be honoured
	logic wdog_hit;  // Watchdog reset while enabled

	// Local wake edge after parasitic pulse rejection
	cantm_wake_filter #(
		.FILT       (FILT_CYC)
	) u_wake (
		.clock      (CLOCK),
		.nrst       (NRST),
		.level      (sync2[`CANTM_SY_WAKE]),
		.rise_en    (WAKE_RISE_EN),
		.fall_en    (WAKE_FALL_EN),
		.wake_event (lw_event)
	);

	assign wake_ev  = lw_event || (BUS_WAKE_EVENT && BUS_WAKE_EN);
	assign no_src   = !(WAKE_RISE_EN || WAKE_FALL_EN || BUS_WAKE_EN);
	assign sleep_ok = !pend && !wake_ev && !no_src;
	assign wdog_hit = WDOG_ENABLE && WDOG_RESET;

	// ======================================================
	// Mode state machine
	// ======================================================
	cantm_mode_e mode;      // Single operating state
	cantm_mode_e next_mode; // Next operating state
	cantm_cnt_t  cnt;       // Time spent in the current state
	cantm_cnt_t  next_cnt;  // Next time count
	logic        cnt_done;  // Start-up or inhibit-off time over
	logic        wr_norm;   // Normal requested
	logic        wr_stby;   // Standby requested
	logic        wr_sleep;  // Sleep requested

	assign wr_norm  = MODE_WRITE && DEVICE_MODE_FIELD == `CANTM_DEV_NORMAL;
	assign wr_stby  = MODE_WRITE && DEVICE_MODE_FIELD == `CANTM_DEV_STANDBY;
	assign wr_sleep = MODE_WRITE && DEVICE_MODE_FIELD == `CANTM_DEV_SLEEP;
	assign cnt_done = cnt >= ((mode == CANTM_OFF) ? START_CYC - 1 :
		INH_OFF_CYC - 1);

	// Next mode, battery loss overrides everything
	always_comb
	begin
		next_mode = mode;
		if (!bat_on)
			next_mode = CANTM_OFF;
		else
		begin
			case (mode)
				// Boot, then Standby after the start-up time
				CANTM_OFF:
					if (cnt_done)
						next_mode = CANTM_STBY;
				// Wake-up alone never leaves Standby
				CANTM_STBY:
					if (wdog_hit)
						next_mode = CANTM_MRST;
					else if (wr_norm)
						next_mode = CANTM_NORM;
					else if (wr_sleep && sleep_ok)
						next_mode = CANTM_SLEEP;
				// Full function
				CANTM_NORM:
					if (ovt)
						next_mode = CANTM_OVT;
					else if (wdog_hit)
						next_mode = CANTM_MRST;
					else if (wr_stby && io_ok)
						next_mode = CANTM_STBY;
					else if (wr_sleep)
						next_mode = sleep_ok ? CANTM_SLEEP :
							CANTM_STBY;
				// Regulator off until a wake-up, a watchdog reset or a Normal or Standby write with io supply
				CANTM_SLEEP:
					if (pend || wake_ev)
						next_mode = CANTM_STBY;
					else if (wdog_hit)
						next_mode = CANTM_MRST;
					else if (wr_norm && io_ok)
						next_mode = CANTM_NORM;
					else if (wr_stby && io_ok)
						next_mode = CANTM_STBY;
				// Inhibit off for the reset time
				CANTM_MRST:
					if (cnt_done)
						next_mode = CANTM_STBY;
				// Cooling down
				CANTM_OVT:
					if (!ovt)
						next_mode = CANTM_STBY;
				default:
					next_mode = CANTM_OFF;
			endcase
		end
	end

	// Counter clears on every change of state and on low battery
	assign next_cnt = (next_mode != mode || !bat_on) ? '0 :
		(cnt_done ? cnt : cnt + cantm_cnt_t'(1));

	// State registers
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			mode <= CANTM_OFF;
			cnt  <= '0;
		end
		else
		begin
			mode <= next_mode;
			cnt  <= next_cnt;
		end
	end

	// Wake pending, set beats clear, wiped in Power Off
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
			pend <= 1'b0;
		else if (mode == CANTM_OFF)
			pend <= 1'b0;
		else if (wake_ev)
			pend <= 1'b1;
		else if (WAKE_CLEAR)
			pend <= 1'b0;
	end

	// ======================================================
	// Transceiver
	// ======================================================
	logic trx_norm;   // Sub-state transmits
	logic rx_stream;  // Sub-state reports the bus
	logic trx_norm_d; // Previous trx_norm
	logic tx_block;   // Low at entry, wait for high
	logic timed_out;  // Dominant time-out reached
	logic clamp;      // Receive pin stuck recessive
	logic rx_d1;      // Receive output one cycle ago
	logic rx_d2;      // Receive output two cycles ago
	logic next_drive; // Next driver state
	logic next_rx;    // Next receive output

	// Sub-state from the transceiver field inside Normal
	assign rx_stream = (mode == CANTM_NORM) &&
		TRANSCEIVER_MODE_FIELD != `CANTM_TRX_STANDBY;
	assign trx_norm  = rx_stream &&
		TRANSCEIVER_MODE_FIELD != `CANTM_TRX_SILENT;

	// Timer runs only while a dominant is requested
	cantm_dom_timer #(
		.LIMIT     (DOM_TO_CYC)
	) u_dom (
		.clock     (CLOCK),
		.nrst      (NRST),
		.tx_low    (tx_low && trx_norm),
		.timed_out (timed_out)
	);

	// Drive only with every guard released, never in the entry cycle
	assign next_drive = trx_norm && trx_norm_d && tx_low && !timed_out &&
		!tx_block && !clamp;

	// Bus level, or high with wake pending pulling it low
	assign next_rx = (mode == CANTM_OFF) ? 1'b1 :
		(rx_stream ? bus_rec : !pend);

	// Entry block and clamp detection
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			trx_norm_d <= 1'b0;
			tx_block   <= 1'b0;
			clamp      <= 1'b0;
			rx_d1      <= 1'b1;
			rx_d2      <= 1'b1;
		end
		else
		begin
			trx_norm_d <= trx_norm;
			rx_d1      <= RX_DATA_OUT;
			rx_d2      <= rx_d1;
			// Entering with a low input holds recessive
			if (!tx_low)
				tx_block <= 1'b0;
			else if (trx_norm && !trx_norm_d)
				tx_block <= 1'b1;
			// Driven low yet read high means a clamp
			if (!rx_stream)
				clamp <= 1'b0;
			else if (!rx_d2 && rx_sens)
				clamp <= 1'b1;
		end
	end

	// Bus, receive and inhibit outputs
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			BUS_DRIVE_DOM         <= 1'b0;
			BUS_BIAS_ON           <= 1'b0;
			BUS_HIGH_OHMIC        <= 1'b1;
			RX_DATA_OUT           <= 1'b1;
			REGULATOR_INHIBIT_OUT <= 1'b0;
			WAKE_PENDING          <= 1'b0;
			DEVICE_MODE           <= 3'h0;
		end
		else
		begin
			BUS_DRIVE_DOM         <= next_drive;
			BUS_BIAS_ON           <= trx_norm || rx_stream;
			BUS_HIGH_OHMIC        <= mode == CANTM_OFF ||
				mode == CANTM_SLEEP || mode == CANTM_OVT;
			RX_DATA_OUT           <= next_rx;
			REGULATOR_INHIBIT_OUT <= inh_on(next_mode);
			WAKE_PENDING          <= pend;
			DEVICE_MODE           <= next_mode;
		end
	end

	// ======================================================
	// Serial port pins
	// ======================================================
	logic spi_en;  // Port usable in this mode
	logic spi_act; // Port usable and selected
	logic sck_d;   // Previous serial clock, idles low

	assign spi_en  = mode == CANTM_STBY || mode == CANTM_NORM ||
		mode == CANTM_MRST || (mode == CANTM_SLEEP && io_ok);
	assign spi_act = spi_en && !cs_high;
	assign SERIAL_OUT_OE_N = !spi_act;
	assign SPI_ENABLE = spi_en;

	// Edges count only while selected
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			sck_d            <= 1'b0;
			SERIAL_IN_BIT    <= 1'b0;
			SERIAL_IN_STROBE <= 1'b0;
			SERIAL_OUT_SHIFT <= 1'b0;
			SERIAL_OUT       <= 1'b0;
		end
		else
		begin
			sck_d            <= sck;
			SERIAL_IN_BIT    <= serial_in;
			SERIAL_IN_STROBE <= spi_act && sck && !sck_d;
			SERIAL_OUT_SHIFT <= spi_act && !sck && sck_d;
			SERIAL_OUT       <= SERIAL_OUT_DATA && spi_act;
		end
	end

	// ======================================================
	// Checks
	// ======================================================
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!NRST);

	sequence s_wdog_hit;
		bat_on && mode == CANTM_STBY && wdog_hit;
	endsequence

	sequence s_sleep_refused;
		bat_on && mode == CANTM_NORM && !ovt && !wdog_hit &&
			wr_sleep && !sleep_ok;
	endsequence

	chk_drive_off: assert property (
		!trx_norm |=> !BUS_DRIVE_DOM)
		else $error("driver on outside transmitting sub-state");
	chk_drive_dom: assert property (
		next_drive |=> BUS_DRIVE_DOM && $past(tx_low))
		else $error("dominant request not driven");
	chk_dom_timeout: assert property (
		timed_out |=> !BUS_DRIVE_DOM)
		else $error("driver on after dominant time-out");
	chk_entry_block: assert property (
		trx_norm && !trx_norm_d && tx_low |=> !BUS_DRIVE_DOM [*2])
		else $error("driver on after entry with low input");
	chk_rx_follow: assert property (
		rx_stream |=> RX_DATA_OUT == $past(bus_rec))
		else $error("receive output not following bus");
	chk_rx_wake: assert property (
		bat_on && mode == CANTM_STBY && pend |=> !RX_DATA_OUT)
		else $error("receive output high with wake pending");
	chk_inh_sleep: assert property (
		mode == CANTM_SLEEP |-> !REGULATOR_INHIBIT_OUT)
		else $error("inhibit on in sleep");
	chk_wdog_inh: assert property (
		s_wdog_hit |=> !REGULATOR_INHIBIT_OUT [*2])
		else $error("inhibit not off after watchdog reset");
	chk_sdo_release: assert property (
		cs_high |-> SERIAL_OUT_OE_N ##1 !SERIAL_IN_STROBE)
		else $error("serial output driven while deselected");
	chk_power_off: assert property (
		!bat_on |=> mode == CANTM_OFF && !REGULATOR_INHIBIT_OUT)
		else $error("not in power off on low battery");
	chk_sleep_refuse: assert property (
		s_sleep_refused |=> mode == CANTM_STBY)
		else $error("refused sleep did not give standby");

endmodule

`default_nettype wire

// ### sim/cantm_host.sv
// Host controller model: transmit pin, bus wire and receive readback.
// Assumes the bench calls put just after a rising CLOCK edge.
`timescale 1ns/1ps
`default_nettype none

module cantm_host
(
	input  wire logic drive_dom,
	input  wire logic rx_out,
	input  wire logic clamp,
	output var  logic tx,
	output var  logic tx_driven,
	output var  logic bus_rec,
	output var  logic rx_sense
);
	// ==========================================================
	// Pins
	// ==========================================================
	// Idle recessive from time zero
	initial
	begin
		tx = 1'b1;
		tx_driven = 1'b1;
	end

	// Bus wire: dominant only while the drivers are on
	always_comb bus_rec = !drive_dom;

	// Readback stuck high while a clamp is asked for
	always_comb rx_sense = clamp | rx_out;

	// Set transmit level; low asks for dominant, drv low floats it
	task put(input logic b, input logic drv);
		tx = b;
		tx_driven = drv;
	endtask
endmodule

`default_nettype wire

// ### sim/cantm_mode_ctrl_tb_top.sv
// Self-checking bench of the CAN mode and pin controller.
// Assumes the host model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module cantm_mode_ctrl_tb_top;
	// ==========================================================
	// Signals
	// ==========================================================
	localparam int DOM = 20; // Shortened dominant limit
	logic CLOCK = 1'b0, NRST = 1'b0, BATTERY_ON = 1'b0, OVERTEMP = 1'b0;
	logic IO_SUPPLY_OK = 1'b1, CLAMP = 1'b0, WAKE_IN = 1'b0;
	logic WAKE_RISE_EN = 1'b0, WAKE_FALL_EN = 1'b0, BUS_WAKE_EN = 1'b0;
	logic BUS_WAKE_EVENT = 1'b0, WAKE_CLEAR = 1'b0, WDOG_ENABLE = 1'b0;
	logic WDOG_RESET = 1'b0, MODE_WRITE = 1'b0, SPI_SELECT_N = 1'b1;
	logic SERIAL_CLOCK = 1'b0, SERIAL_IN = 1'b0, SERIAL_OUT_DATA = 1'b0;
	logic [2:0] DEVICE_MODE_FIELD = 3'h0;
	logic [1:0] TRANSCEIVER_MODE_FIELD = 2'h1;
	logic RX_DATA_OUT, BUS_DRIVE_DOM, BUS_BIAS_ON, BUS_HIGH_OHMIC;
	logic REGULATOR_INHIBIT_OUT, WAKE_PENDING, SERIAL_OUT_OE_N;
	logic SPI_ENABLE, SERIAL_IN_BIT, SERIAL_IN_STROBE;
	logic SERIAL_OUT, SERIAL_OUT_SHIFT;
	logic [2:0] DEVICE_MODE;
	wire TX_DATA_IN, TX_DATA_DRIVEN, BUS_RECESSIVE, RX_DATA_SENSE;
	int failures = 0, check_count = 0, seed = 36, k;
	logic b;

	// Clock, 5 ns period
	always #2.5 CLOCK = !CLOCK;

	// ==========================================================
	// Instances
	// ==========================================================
	cantm_mode_ctrl #(.DOM_TO_CYC(DOM), .START_CYC(5), .INH_OFF_CYC(8),
		.FILT_CYC(4)) u_cantm_mode_ctrl (.CLOCK, .NRST, .BATTERY_ON,
		.IO_SUPPLY_OK, .OVERTEMP, .TX_DATA_IN, .TX_DATA_DRIVEN,
		.RX_DATA_OUT, .RX_DATA_SENSE, .BUS_RECESSIVE, .BUS_DRIVE_DOM,
		.BUS_BIAS_ON, .BUS_HIGH_OHMIC, .REGULATOR_INHIBIT_OUT, .WAKE_IN,
		.WAKE_RISE_EN, .WAKE_FALL_EN, .BUS_WAKE_EN, .BUS_WAKE_EVENT,
		.WAKE_CLEAR, .WAKE_PENDING, .WDOG_ENABLE, .WDOG_RESET, .MODE_WRITE,
		.DEVICE_MODE_FIELD, .TRANSCEIVER_MODE_FIELD, .DEVICE_MODE,
		.SPI_SELECT_N, .SERIAL_CLOCK, .SERIAL_IN, .SERIAL_OUT,
		.SERIAL_OUT_OE_N, .SERIAL_OUT_DATA, .SPI_ENABLE, .SERIAL_IN_BIT,
		.SERIAL_IN_STROBE, .SERIAL_OUT_SHIFT);
	cantm_host u_cantm_host (.drive_dom(BUS_DRIVE_DOM), .rx_out(RX_DATA_OUT),
		.clamp(CLAMP), .tx(TX_DATA_IN), .tx_driven(TX_DATA_DRIVEN),
		.bus_rec(BUS_RECESSIVE), .rx_sense(RX_DATA_SENSE));

	// ==========================================================
	// Tasks
	// ==========================================================
	// Wait n edges, then step past them
	task cyc(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask
	// Compare and count
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Bounded wait for a mode code
	task wmode(input logic [2:0] m);
		for (int i = 0; i < 200 && DEVICE_MODE !== m; i++)
			cyc(1);
	endtask
	// One mode write pulse
	task wr(input logic [2:0] f);
		MODE_WRITE = 1'b1;
		DEVICE_MODE_FIELD = f;
		cyc(1);
		MODE_WRITE = 1'b0;
		cyc(2);
	endtask
	// Transmit level through the host model
	task tx(input logic v, input logic drv);
		u_cantm_host.put(v, drv);
		cyc(4);
	endtask
	// One clock pulse, clock back low after; count strobes
	task sck(input logic [7:0] exp);
		logic [7:0] n;
		logic [7:0] m;
		n = 8'h0;
		m = 8'h0;
		SERIAL_IN = 1'($random(seed));
		SERIAL_OUT_DATA = 1'($random(seed));
		SERIAL_CLOCK = 1'b1;
		repeat (6)
		begin
			cyc(1);
			n = n + 8'(SERIAL_IN_STROBE);
		end
		chk(SERIAL_OUT, SERIAL_OUT_DATA & exp[0]);
		SERIAL_CLOCK = 1'b0;
		repeat (6)
		begin
			cyc(1);
			m = m + 8'(SERIAL_OUT_SHIFT);
		end
		chk(n, exp);
		chk(m, exp);
	endtask
	// Pulse a wake clear
	task clr;
		WAKE_CLEAR = 1'b1;
		cyc(1);
		WAKE_CLEAR = 1'b0;
		cyc(2);
	endtask
	// Verdict
	task results;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog against a hang
	initial
	begin
		repeat (5000) @(posedge CLOCK);
		failures++;
		results;
	end

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		cyc(4);
		NRST = 1'b1;
		cyc(10);
		chk(DEVICE_MODE, 8'h0);
		chk({REGULATOR_INHIBIT_OUT, BUS_HIGH_OHMIC, SPI_ENABLE}, 8'h2);
		BATTERY_ON = 1'b1;
		cyc(5);
		chk(DEVICE_MODE, 8'h0);
		wmode(3'h1);
		chk(DEVICE_MODE, 8'h1);
		chk({REGULATOR_INHIBIT_OUT, RX_DATA_OUT}, 8'h3);
		chk(BUS_DRIVE_DOM, 8'h0);
		chk(SERIAL_OUT_OE_N, 8'h1);
		SPI_SELECT_N = 1'b0;
		cyc(4);
		chk(SERIAL_OUT_OE_N, 8'h0);
		for (k = 0; k < 4; k++)
		begin
			sck(8'h1);
			chk(SERIAL_IN_BIT, SERIAL_IN);
		end
		SPI_SELECT_N = 1'b1;
		cyc(4);
		chk(SERIAL_OUT_OE_N, 8'h1);
		sck(8'h0);
		wr(3'h7);
		chk({DEVICE_MODE, BUS_BIAS_ON}, 8'h7);
		chk(REGULATOR_INHIBIT_OUT, 8'h1);
		for (k = 0; k < 16; k++)
		begin
			b = 1'($random(seed));
			tx(b, 1'b1);
			chk(BUS_DRIVE_DOM, !b);
			cyc(3);
			chk(RX_DATA_OUT, b);
			if (!b)
				tx(1'b1, 1'b1);
		end
		tx(1'b1, 1'b1);
		chk(BUS_DRIVE_DOM, 8'h0);
		tx(1'b0, 1'b0);
		chk(BUS_DRIVE_DOM, 8'h0);
		tx(1'b0, 1'b1);
		cyc(DOM - 6);
		chk(BUS_DRIVE_DOM, 8'h1);
		cyc(10);
		chk(BUS_DRIVE_DOM, 8'h0);
		tx(1'b1, 1'b1);
		tx(1'b0, 1'b1);
		chk(BUS_DRIVE_DOM, 8'h1);
		tx(1'b1, 1'b1);
		TRANSCEIVER_MODE_FIELD = 2'h3;
		tx(1'b0, 1'b1);
		chk({BUS_DRIVE_DOM, RX_DATA_OUT}, 8'h1);
		TRANSCEIVER_MODE_FIELD = 2'h0;
		tx(1'b1, 1'b1);
		chk({BUS_BIAS_ON, RX_DATA_OUT}, 8'h1);
		TRANSCEIVER_MODE_FIELD = 2'h2;
		CLAMP = 1'b1;
		tx(1'b0, 1'b1);
		cyc(10);
		chk(BUS_DRIVE_DOM, 8'h0);
		CLAMP = 1'b0;
		tx(1'b1, 1'b1);
		tx(1'b0, 1'b1);
		chk(BUS_DRIVE_DOM, 8'h0);
		wr(3'h4);
		chk(DEVICE_MODE, 8'h1);
		wr(3'h7);
		tx(1'b0, 1'b1);
		chk(BUS_DRIVE_DOM, 8'h0);
		tx(1'b1, 1'b1);
		tx(1'b0, 1'b1);
		chk(BUS_DRIVE_DOM, 8'h1);
		tx(1'b1, 1'b1);
		OVERTEMP = 1'b1;
		cyc(4);
		chk({DEVICE_MODE, SPI_ENABLE, BUS_HIGH_OHMIC}, 8'h1d);
		OVERTEMP = 1'b0;
		wmode(3'h1);
		WAKE_RISE_EN = 1'b1;
		wr(3'h1);
		chk({DEVICE_MODE, REGULATOR_INHIBIT_OUT}, 8'h4);
		chk(BUS_HIGH_OHMIC, 8'h1);
		IO_SUPPLY_OK = 1'b0;
		cyc(4);
		chk(SPI_ENABLE, 8'h0);
		wr(3'h4);
		chk(DEVICE_MODE, 8'h2);
		IO_SUPPLY_OK = 1'b1;
		WAKE_IN = 1'b1;
		cyc(2);
		WAKE_IN = 1'b0;
		cyc(10);
		chk(DEVICE_MODE, 8'h2);
		WAKE_IN = 1'b1;
		cyc(12);
		chk({DEVICE_MODE, REGULATOR_INHIBIT_OUT}, 8'h3);
		chk({WAKE_PENDING, RX_DATA_OUT}, 8'h2);
		wr(3'h1);
		chk(DEVICE_MODE, 8'h1);
		clr;
		WAKE_RISE_EN = 1'b0;
		wr(3'h1);
		chk(DEVICE_MODE, 8'h1);
		WAKE_FALL_EN = 1'b1;
		wr(3'h1);
		chk(DEVICE_MODE, 8'h2);
		WAKE_IN = 1'b0;
		cyc(12);
		chk(DEVICE_MODE, 8'h1);
		clr;
		BUS_WAKE_EN = 1'b1;
		wr(3'h1);
		chk(DEVICE_MODE, 8'h2);
		BUS_WAKE_EVENT = 1'b1;
		cyc(1);
		BUS_WAKE_EVENT = 1'b0;
		cyc(3);
		chk({DEVICE_MODE, REGULATOR_INHIBIT_OUT}, 8'h3);
		clr;
		WDOG_ENABLE = 1'b1;
		WDOG_RESET = 1'b1;
		cyc(1);
		WDOG_RESET = 1'b0;
		cyc(2);
		chk({DEVICE_MODE, REGULATOR_INHIBIT_OUT}, 8'hc);
		wmode(3'h1);
		chk(REGULATOR_INHIBIT_OUT, 8'h1);
		BATTERY_ON = 1'b0;
		cyc(4);
		chk({DEVICE_MODE, REGULATOR_INHIBIT_OUT, BUS_HIGH_OHMIC}, 8'h1);
		results;
	end
endmodule

`default_nettype wire
